// File: tlvip_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

package tlvip_pkg;

  localparam int NUM_VEC = 10;
  localparam int NUM_SRC = 44;
  localparam int VEC_ADDR_W = 20;
  localparam int VEC_IDX_W = 4;

  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_0 = 20'h00003;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_1 = 20'h0000b;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_2 = 20'h00013;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_3 = 20'h0001b;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_4 = 20'h00023;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_5 = 20'h0002b;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_6 = 20'h00033;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_7 = 20'h0003b;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_8 = 20'h00043;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_9 = 20'h0004b;

  typedef logic [1:0] tlvip_level_t;
  // Numeric order is the rank order
  localparam tlvip_level_t LVL_NONE = 2'h0;
  localparam tlvip_level_t LVL_LOW = 2'h1;
  localparam tlvip_level_t LVL_HIGH = 2'h2;
  localparam tlvip_level_t LVL_TOP = 2'h3;

  localparam logic [NUM_VEC-1:0] PEND_RST = 10'h000;
  localparam logic [2:0] SVC_RST = 3'h0;

  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic timer_two_source;
    logic timer0_low_half;
    logic ext_irq_four;
    logic usb_host_controller_a_bus_active;
    logic usb_host_controller_b_bus_active;
    logic remote_rx;
    logic ext_irq_three;
    logic ext_irq_five;
    logic base_timer;
    logic timer0_high_half;
    logic ext_irq_six;
    logic usb_host_controller_a_connect;
    logic usb_host_controller_a_disconnect;
    logic usb_host_controller_a_resume;
    logic timer1_low_half;
    logic timer1_high_half;
    logic ext_irq_seven;
    logic audio_interface_start;
    logic two_wire_bus_unit;
    logic usb_host_controller_b_connect;
    logic usb_host_controller_b_disconnect;
    logic usb_host_controller_b_resume;
    logic sync_serial_first;
    logic full_duplex_serial_port_rx_done;
    logic sync_serial_second;
    logic sync_serial_fourth;
    logic full_duplex_serial_port_buf_empty;
    logic full_duplex_serial_port_tx_done;
    logic audio_interface_end;
    logic converter_done;
    logic timer_six;
    logic timer_seven;
    logic usb_host_controller_ack;
    logic usb_host_controller_nak;
    logic usb_host_controller_error;
    logic usb_host_controller_stall;
    logic port0_pin;
    logic pulse_width_chan_a;
    logic pulse_width_chan_b;
    logic timer_four;
    logic timer_five;
    logic usb_host_controller_sof;
  } tlvip_src_t;

  typedef struct packed {
    logic req;
    logic [VEC_ADDR_W-1:0] addr;
    tlvip_level_t level;
  } tlvip_grant_t;

  localparam tlvip_grant_t GRANT_RST = '0;
  localparam logic [VEC_IDX_W-1:0] IDX_RST = 4'h0;

  // Sources onto vectors; bit n is the vector at index n
  function automatic logic [NUM_VEC-1:0] tlvip_merge(input tlvip_src_t s);
    logic [NUM_VEC-1:0] v;
    v = '0;
    v[0] = s.ext_irq_zero;
    v[1] = s.ext_irq_one;
    v[2] = s.timer_two_source | s.timer0_low_half | s.ext_irq_four
      | s.usb_host_controller_a_bus_active | s.usb_host_controller_b_bus_active
      | s.remote_rx;
    v[3] = s.ext_irq_three | s.ext_irq_five | s.base_timer;
    v[4] = s.timer0_high_half | s.ext_irq_six | s.usb_host_controller_a_connect
      | s.usb_host_controller_a_disconnect | s.usb_host_controller_a_resume;
    v[5] = s.timer1_low_half | s.timer1_high_half | s.ext_irq_seven
      | s.audio_interface_start | s.two_wire_bus_unit
      | s.usb_host_controller_b_connect | s.usb_host_controller_b_disconnect
      | s.usb_host_controller_b_resume;
    v[6] = s.sync_serial_first | s.full_duplex_serial_port_rx_done;
    v[7] = s.sync_serial_second | s.sync_serial_fourth
      | s.full_duplex_serial_port_buf_empty | s.full_duplex_serial_port_tx_done
      | s.audio_interface_end;
    v[8] = s.converter_done | s.timer_six | s.timer_seven | s.usb_host_controller_ack
      | s.usb_host_controller_nak | s.usb_host_controller_error
      | s.usb_host_controller_stall;
    v[9] = s.port0_pin | s.pulse_width_chan_a | s.pulse_width_chan_b | s.timer_four
      | s.timer_five | s.usb_host_controller_sof;
    return v;
  endfunction

  function automatic logic [VEC_ADDR_W-1:0] tlvip_vec_addr(input logic [VEC_IDX_W-1:0] i);
    logic [VEC_ADDR_W-1:0] a;
    a = VEC_ADDR_0;
    case (i)
      4'h1: a = VEC_ADDR_1;
      4'h2: a = VEC_ADDR_2;
      4'h3: a = VEC_ADDR_3;
      4'h4: a = VEC_ADDR_4;
      4'h5: a = VEC_ADDR_5;
      4'h6: a = VEC_ADDR_6;
      4'h7: a = VEC_ADDR_7;
      4'h8: a = VEC_ADDR_8;
      4'h9: a = VEC_ADDR_9;
      default: a = VEC_ADDR_0;
    endcase
    return a;
  endfunction

  // Upper choice is highest for the two pin vectors, high for the rest
  function automatic tlvip_level_t tlvip_vec_level(input int i, input logic upper);
    tlvip_level_t l;
    l = LVL_LOW;
    if (upper) begin
      l = (i < 2) ? LVL_TOP : LVL_HIGH;
    end
    return l;
  endfunction

  // Highest in-service level, none when idle
  function automatic tlvip_level_t tlvip_svc_level(input logic [2:0] svc);
    tlvip_level_t l;
    l = LVL_NONE;
    if (svc[2]) begin
      l = LVL_TOP;
    end else if (svc[1]) begin
      l = LVL_HIGH;
    end else if (svc[0]) begin
      l = LVL_LOW;
    end
    return l;
  endfunction

endpackage

module tlvip_ctrl (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire tlvip_pkg::tlvip_src_t src,
  input wire logic [tlvip_pkg::NUM_VEC-1:0] vec_enable,
  input wire logic [tlvip_pkg::NUM_VEC-1:0] vec_upper_sel,
  input wire logic irq_ack,
  input wire logic irq_ret,
  output var tlvip_pkg::tlvip_grant_t grant,
  output logic [1:0] service_level,
  output logic [tlvip_pkg::NUM_VEC-1:0] pending
);

  logic [tlvip_pkg::NUM_VEC-1:0] pend_reg;
  logic [tlvip_pkg::NUM_VEC-1:0] pend_next;
  logic [2:0] svc_reg;
  logic [2:0] svc_next;
  tlvip_pkg::tlvip_grant_t grant_reg;
  tlvip_pkg::tlvip_grant_t grant_next;
  logic [tlvip_pkg::VEC_IDX_W-1:0] idx_reg;
  logic [tlvip_pkg::VEC_IDX_W-1:0] idx_next;
  tlvip_pkg::tlvip_level_t svc_lvl_reg;
  tlvip_pkg::tlvip_level_t svc_lvl_next;
  logic [tlvip_pkg::NUM_VEC-1:0] raw_req;
  logic accept;

  assign raw_req = tlvip_pkg::tlvip_merge(src);
  assign accept = irq_ack & grant_reg.req;

  // Pending bits and in-service levels
  always_comb begin
    pend_next = pend_reg;
    svc_next = svc_reg;
    if (accept) begin
      pend_next[idx_reg] = 1'b0;
    end
    // A new request in the accept cycle is kept
    pend_next = pend_next | raw_req;
    if (irq_ret) begin
      if (svc_next[2]) begin
        svc_next[2] = 1'b0;
      end else if (svc_next[1]) begin
        svc_next[1] = 1'b0;
      end else begin
        svc_next[0] = 1'b0;
      end
    end
    if (accept) begin
      svc_next[grant_reg.level - 2'h1] = 1'b1;
    end
    // Decoded ahead so the level output leaves a flop
    svc_lvl_next = tlvip_pkg::tlvip_svc_level(svc_next);
  end

  // Arbitration over next-cycle state
  always_comb begin
    tlvip_pkg::tlvip_level_t cur;
    tlvip_pkg::tlvip_level_t best;
    tlvip_pkg::tlvip_level_t lv;
    logic [tlvip_pkg::VEC_IDX_W-1:0] best_idx;
    cur = tlvip_pkg::tlvip_svc_level(svc_next);
    best = tlvip_pkg::LVL_NONE;
    best_idx = '0;
    lv = tlvip_pkg::LVL_NONE;
    for (int i = 0; i < tlvip_pkg::NUM_VEC; i++) begin
      lv = tlvip_pkg::tlvip_vec_level(i, vec_upper_sel[i]);
      // Strict compare in ascending order keeps the lowest vector on a tie
      if (pend_next[i] && vec_enable[i] && lv > cur && lv > best) begin
        best = lv;
        best_idx = i[tlvip_pkg::VEC_IDX_W-1:0];
      end
    end
    grant_next.req = (best != tlvip_pkg::LVL_NONE);
    grant_next.addr = tlvip_pkg::tlvip_vec_addr(best_idx);
    grant_next.level = best;
    idx_next = best_idx;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_reg <= tlvip_pkg::PEND_RST;
      svc_reg <= tlvip_pkg::SVC_RST;
      grant_reg <= tlvip_pkg::GRANT_RST;
      idx_reg <= tlvip_pkg::IDX_RST;
      svc_lvl_reg <= tlvip_pkg::LVL_NONE;
    end else begin
      pend_reg <= pend_next;
      svc_reg <= svc_next;
      svc_lvl_reg <= svc_lvl_next;
      grant_reg <= grant_next;
      idx_reg <= idx_next;
    end
  end

  assign grant = grant_reg;
  assign service_level = svc_lvl_reg;
  assign pending = pend_reg;

endmodule

`default_nettype wire

// File: tlvip_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tlvip_ctrl_sva (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire tlvip_pkg::tlvip_src_t src,
  input wire logic irq_ack,
  input wire logic irq_ret,
  input wire tlvip_pkg::tlvip_grant_t grant,
  input wire logic [1:0] service_level,
  input wire logic [9:0] pending
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    irq_ack && grant.req;
  endsequence
  a_rst_clear: assert property ($past(sys_rst) |-> grant == '0 && pending == '0)
    else $error("outputs not clear");
  a_pend_hold: assert property (!irq_ack |=> ($past(pending) & ~pending) == '0)
    else $error("pending lost");
  a_ack_raise: assert property (s_take |=> service_level == $past(grant.level))
    else $error("level not raised");
  a_ret_drop: assert property (irq_ret && !irq_ack && service_level != 2'h0
    |=> service_level < $past(service_level))
    else $error("level not dropped");
  a_svc_hold: assert property (!irq_ret && !irq_ack |=> $stable(service_level))
    else $error("level moved");
  a_above_svc: assert property (grant.req |-> grant.level > service_level)
    else $error("offer not above");
  a_vec_addr: assert property (grant.req |-> grant.addr[2:0] == 3'h3
    && grant.addr <= 20'h0004b)
    else $error("bad vector");
  a_pin_level: assert property (grant.req && grant.addr < 20'h00013 |-> grant.level != 2'h2)
    else $error("pin level");
  a_src_pend: assert property (src.timer_four |=> pending[9])
    else $error("source lost");
endmodule
bind tlvip_ctrl tlvip_ctrl_sva u_tlvip_ctrl_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .src(src), .irq_ack(irq_ack), .irq_ret(irq_ret), .grant(grant),
  .service_level(service_level), .pending(pending));
`default_nettype wire

// File: tlvip_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlvip_core_model (
  input wire logic sys_clk,
  input wire logic take,
  input wire logic [1:0] slow,
  input wire tlvip_pkg::tlvip_grant_t grant,
  output logic irq_ack
);
  logic [1:0] wait_reg = 2'h0;
  logic ack_reg = 1'b0;
  assign irq_ack = ack_reg;
  // Accepts an offer after slow idle cycles, one-cycle pulse
  always @(posedge sys_clk) begin
    if (!take || !grant.req || ack_reg) begin
      wait_reg <= 2'h0;
      ack_reg <= 1'b0;
    end else if (wait_reg == slow) begin
      ack_reg <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb_tlvip_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tlvip_ctrl;
  logic sys_clk = 1'b0, sys_rst = 1'b1, irq_ret = 1'b0, take = 1'b0, irq_ack;
  logic [1:0] slow = 2'h0, service_level;
  logic [9:0] en = 10'h000, sel = 10'h000, pending;
  tlvip_pkg::tlvip_src_t src = '0;
  tlvip_pkg::tlvip_grant_t grant;
  int fail_count = 0, n_checks = 0;
  // Vector index of each source, first field first
  localparam logic [175:0] MAP = 176'h01222222333444445555555566777778888888999999;
  always #50 sys_clk = ~sys_clk;
  tlvip_ctrl u_tlvip_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .src(src),
    .vec_enable(en), .vec_upper_sel(sel), .irq_ack(irq_ack), .irq_ret(irq_ret),
    .grant(grant), .service_level(service_level), .pending(pending));
  tlvip_core_model u_tlvip_core_model (.sys_clk(sys_clk), .take(take), .slow(slow),
    .grant(grant), .irq_ack(irq_ack));
  task automatic test_done();
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [19:0] e, logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rst();
    sys_rst = 1'b1;
    take = 1'b0;
    cyc(2);
    sys_rst = 1'b0;
  endtask
  task automatic pulse(tlvip_pkg::tlvip_src_t s);
    src = s;
    cyc(1);
    src = '0;
  endtask
  task automatic ret();
    irq_ret = 1'b1;
    cyc(1);
    irq_ret = 1'b0;
  endtask
  task automatic wait_svc(logic [1:0] e);
    int i;
    for (i = 0; i < 12 && service_level !== e; i++) cyc(1);
    chk("service_level", 20'(e), 20'(service_level));
    if (i == 12) test_done();
  endtask
  task automatic t_map();
    for (int i = 0; i < 44; i++) begin
      rst();
      pulse(tlvip_pkg::tlvip_src_t'(44'h1 << (43 - i)));
      chk("pending", 20'(10'h1 << MAP[175-4*i -: 4]), 20'(pending));
      chk("req", 20'h0, 20'(grant.req));
    end
  endtask
  task automatic t_walk();
    tlvip_pkg::tlvip_src_t s;
    s = '0;
    s.timer_four = 1'b1;
    rst();
    en = 10'h3ff;
    pulse(s);
    chk("addr", 20'h0004b, grant.addr);
    chk("level", 20'h1, 20'(grant.level));
    take = 1'b1;
    slow = 2'h2;
    wait_svc(2'h1);
    chk("pending", 20'h0, 20'(pending));
    take = 1'b0;
    ret();
    chk("service_level", 20'h0, 20'(service_level));
  endtask
  task automatic t_arb();
    tlvip_pkg::tlvip_src_t s;
    s = '0;
    s.ext_irq_one = 1'b1;
    s.converter_done = 1'b1;
    s.port0_pin = 1'b1;
    rst();
    sel = 10'h300;
    slow = 2'h0;
    pulse(s);
    chk("addr", 20'h00043, grant.addr);
    take = 1'b1;
    wait_svc(2'h2);
    take = 1'b0;
    chk("pending", 20'h00202, 20'(pending));
    ret();
    chk("addr", 20'h0004b, grant.addr);
  endtask
  task automatic t_nest();
    tlvip_pkg::tlvip_src_t s;
    s = '0;
    s.sync_serial_first = 1'b1;
    rst();
    sel = 10'h001;
    take = 1'b1;
    pulse(s);
    wait_svc(2'h1);
    s = '0;
    s.remote_rx = 1'b1;
    pulse(s);
    cyc(2);
    chk("req", 20'h0, 20'(grant.req));
    s = '0;
    s.ext_irq_zero = 1'b1;
    pulse(s);
    wait_svc(2'h3);
    take = 1'b0;
    ret();
    chk("service_level", 20'h1, 20'(service_level));
    ret();
    chk("addr", 20'h00013, grant.addr);
  endtask
  initial begin
    rst();
    t_map();
    t_walk();
    t_arb();
    t_nest();
    test_done();
  end
endmodule
`default_nettype wire
